// ==== inc/line_codec_pkg.sv ====
// Contract
// RULE_01 - Transmit merges NRZ data and bit clock into Manchester line data.
// RULE_02 - Receive turns Manchester line data into NRZ data and a clock.
// RULE_03 - Line rate is 10 Mb/s, one data bit per bit cell.
// RULE_04 - Transmit bit clock is the 20 MHz oscillator divided by 2.
// RULE_05 - Both clocks go to the MAC; receive clock comes from line data.
// RULE_06 - Carrier present is high while data arrives on the receive line.
// RULE_07 - Collision flagged while a 10 MHz tone is on the collision input. The code holds it low in MAC and codec loopback.
// RULE_08 - Every signal given to the MAC is also driven on user pins.
// RULE_09 - Three loopback modes: at the MAC, the codec or the transceiver.
// RULE_10 - Transceiver always echoes the sent packet onto the receive path.
// RULE_11 - Self-received checksum or source mismatch sets monitor bad flag.
// RULE_12 - External codec select high routes MAC signals to off-chip pins.
// RULE_13 - Cell first half is the inverted bit, second half the true bit.
package line_codec_pkg;

    // Clock and line timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int OSC_FREQ_HZ = 20_000_000;
    localparam int OSC_DIVIDE = 2;
    localparam int BIT_RATE_BPS = 10_000_000;
    localparam int OSC_PERIOD_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int HALF_CELL_CYCLES = OSC_PERIOD_CYCLES * OSC_DIVIDE / 2;
    localparam int BIT_CELL_CYCLES = CLK_FREQ_HZ / BIT_RATE_BPS;
    localparam int MID_EDGE_MIN = (BIT_CELL_CYCLES * 3) / 4 - 1;
    localparam int CARRIER_TIMEOUT = BIT_CELL_CYCLES + HALF_CELL_CYCLES;
    localparam int COL_WINDOW_CYCLES = BIT_CELL_CYCLES + HALF_CELL_CYCLES;

    // Reset level of every output and one-bit register
    localparam logic RESET_LEVEL = 1'b0;

    // Loopback selection
    typedef enum logic [1:0] {
        LOOP_NONE = 2'h0,
        LOOP_MAC = 2'h1,
        LOOP_CODEC = 2'h2,
        LOOP_XCVR = 2'h3
    } loop_mode_t;

    // Decoder lock states, one-hot
    typedef enum logic [1:0] {
        DEC_IDLE = 2'h1,
        DEC_LOCK = 2'h2
    } dec_state_t;

endpackage : line_codec_pkg

// ==== logic/manchester_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
module manchester_decoder
    import line_codec_pkg::*;
#(
    parameter int CELL = BIT_CELL_CYCLES,
    parameter int MID_MIN = MID_EDGE_MIN,
    parameter int TIMEOUT = CARRIER_TIMEOUT
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic line_in,
    output logic rx_data,
    output logic rx_clock,
    output logic carrier
);
    localparam int CW = $clog2(TIMEOUT + 1);

    // Refuse timing the lock logic cannot serve
    if (MID_MIN <= CELL / 2 || MID_MIN >= CELL || TIMEOUT <= CELL)
    begin : g_bad_param
        $error("decoder timing parameters out of range");
    end

    dec_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic prev_ff, nxt_prev;
    logic data_ff, nxt_data;
    logic clk_ff, nxt_clk;
    logic line_edge, mid_edge;

    // Lock, mid-cell edge pick and clock recovery
    always_comb
    begin
        line_edge = line_in ^ prev_ff;
        // RULE_03 one cell spacing
        mid_edge = (state_ff == DEC_LOCK) && line_edge &&
                   (cnt_ff >= CW'(MID_MIN));
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_data = data_ff;
        nxt_prev = line_in;
        unique case (state_ff)
            DEC_IDLE:
            begin
                // RULE_06 carrier on edge
                if (line_edge)
                begin
                    nxt_state = DEC_LOCK;
                    nxt_cnt = '0;
                    nxt_data = line_in;
                end
            end
            DEC_LOCK:
            begin
                // RULE_13 second half true
                if (mid_edge)
                begin
                    nxt_cnt = '0;
                    nxt_data = line_in;
                end
                else if (cnt_ff == CW'(TIMEOUT))
                    nxt_state = DEC_IDLE;
                else
                    nxt_cnt = cnt_ff + 1'b1;
            end
            default:
                nxt_state = DEC_IDLE;
        endcase
        // RULE_05 clock from data
        nxt_clk = (nxt_state == DEC_LOCK) && (nxt_cnt >= CW'(CELL / 2));
    end

    // Decoder registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= DEC_IDLE;
            cnt_ff <= '0;
            prev_ff <= RESET_LEVEL;
            data_ff <= RESET_LEVEL;
            clk_ff <= RESET_LEVEL;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            prev_ff <= nxt_prev;
            data_ff <= nxt_data;
            clk_ff <= nxt_clk;
        end
    end

    // RULE_02 NRZ data out
    assign rx_data = data_ff;
    assign rx_clock = clk_ff;
    assign carrier = (state_ff == DEC_LOCK);

    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);

    // Lock and data checks
    AST_DEC_LOCK: assert property ( // RULE_06
        (state_ff == DEC_IDLE) && line_edge |=>
            carrier && rx_data == $past(line_in))
        else $error("decoder did not lock on first edge");
    AST_DEC_MID: assert property ( // RULE_02
        mid_edge |=> (rx_data == $past(line_in) && !rx_clock) ##5 rx_clock)
        else $error("mid-cell data or clock wrong");
    AST_DEC_CLK: assert property ( // RULE_05
        rx_clock |-> carrier)
        else $error("receive clock without carrier");
endmodule : manchester_decoder
`default_nettype wire

// ==== logic/manchester_line_codec.sv ====
`timescale 1ns/100ps
`default_nettype none
module manchester_line_codec
    import line_codec_pkg::*;
#(
    parameter int HALF_CELL = HALF_CELL_CYCLES,
    parameter int COL_WINDOW = COL_WINDOW_CYCLES
)
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic MAC_TX_DATA,
    input wire logic MAC_TX_EN,
    input wire logic [1:0] LOOP_MODE,
    input wire logic EXTERNAL_CODEC_SELECT,
    input wire logic LINE_RX,
    input wire logic LINE_COL,
    input wire logic OFFCHIP_TX_CLOCK,
    input wire logic OFFCHIP_RX_DATA,
    input wire logic OFFCHIP_RX_CLOCK,
    input wire logic OFFCHIP_CARRIER,
    input wire logic OFFCHIP_COLLISION,
    input wire logic MON_CHECK,
    input wire logic MON_CRC_OK,
    input wire logic MON_SRC_OK,
    output logic LINE_TX,
    output logic LINE_TX_EN,
    output logic OFFCHIP_TX_DATA,
    output logic OFFCHIP_TX_EN,
    output logic MAC_TRANSMIT_BIT_CLOCK,
    output logic MAC_RX_DATA,
    output logic MAC_RX_CLOCK,
    output logic MAC_CARRIER_PRESENT,
    output logic MAC_COLLISION,
    output logic PIN_TRANSMIT_BIT_CLOCK,
    output logic PIN_RX_CLOCK,
    output logic PIN_RX_DATA,
    output logic PIN_CARRIER_PRESENT,
    output logic PIN_COLLISION,
    output logic MONITOR_BAD_FLAG
);
    localparam int HW = $clog2(HALF_CELL);
    localparam int CWW = $clog2(COL_WINDOW + 1);

    // Refuse timing the counters cannot serve
    if (HALF_CELL < 2 || COL_WINDOW <= HALF_CELL)
    begin : g_bad_param
        $error("codec timing parameters out of range");
    end

    loop_mode_t mode;
    logic ext_sel, line_on, dec_in;
    logic dec_data, dec_clock, dec_carrier;

    // Path selection
    assign mode = loop_mode_t'(LOOP_MODE);
    assign ext_sel = EXTERNAL_CODEC_SELECT;
    assign line_on = !ext_sel && (mode == LOOP_NONE || mode == LOOP_XCVR);

    logic [HW-1:0] half_cnt_ff, nxt_half_cnt;
    logic phase_ff, nxt_phase;
    logic bit_ff, nxt_bit;
    logic active_ff, nxt_active;
    logic cell_end;

    // Bit cell timing, oscillator divided by two
    always_comb
    begin
        cell_end = phase_ff && (half_cnt_ff == HW'(HALF_CELL - 1));
        nxt_half_cnt = half_cnt_ff + 1'b1;
        nxt_phase = phase_ff;
        nxt_bit = bit_ff;
        nxt_active = active_ff;
        // RULE_04 divide by two
        if (half_cnt_ff == HW'(HALF_CELL - 1))
        begin
            nxt_half_cnt = '0;
            nxt_phase = !phase_ff;
        end
        // RULE_01 sample NRZ bit
        if (cell_end)
        begin
            nxt_bit = MAC_TX_DATA;
            nxt_active = MAC_TX_EN;
        end
    end

    // Encoder registers
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            half_cnt_ff <= '0;
            phase_ff <= RESET_LEVEL;
            bit_ff <= RESET_LEVEL;
            active_ff <= RESET_LEVEL;
        end
        else
        begin
            half_cnt_ff <= nxt_half_cnt;
            phase_ff <= nxt_phase;
            bit_ff <= nxt_bit;
            active_ff <= nxt_active;
        end
    end

    logic col_prev_ff, nxt_col_prev;
    logic [CWW-1:0] col_tmr_ff, nxt_col_tmr;
    logic col_det_ff, nxt_col_det;
    logic col_edge;

    // Collision tone detector, needs two edges in one window
    always_comb
    begin
        col_edge = LINE_COL ^ col_prev_ff;
        nxt_col_prev = LINE_COL;
        nxt_col_tmr = col_tmr_ff;
        nxt_col_det = col_det_ff;
        // RULE_07 detect collision tone
        if (col_edge)
        begin
            nxt_col_det = col_det_ff || (col_tmr_ff != '0);
            nxt_col_tmr = CWW'(COL_WINDOW);
        end
        else if (col_tmr_ff != '0)
            nxt_col_tmr = col_tmr_ff - 1'b1;
        else
            nxt_col_det = 1'b0;
    end

    // Collision registers
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            col_prev_ff <= RESET_LEVEL;
            col_tmr_ff <= '0;
            col_det_ff <= RESET_LEVEL;
        end
        else
        begin
            col_prev_ff <= nxt_col_prev;
            col_tmr_ff <= nxt_col_tmr;
            col_det_ff <= nxt_col_det;
        end
    end

    logic enc_ff, nxt_enc;
    logic tx_en_prev_ff, nxt_tx_en_prev;
    logic nxt_line_tx, nxt_line_tx_en, nxt_off_data, nxt_off_en;
    logic nxt_txclk, nxt_rxdata, nxt_rxclk, nxt_carrier, nxt_col;
    logic nxt_mon, tx_start, mon_fail;

    // RULE_09 codec loopback feed
    assign dec_in = (mode == LOOP_CODEC) ? enc_ff : LINE_RX;

    // Receive side decoder
    manchester_decoder #(
        .CELL(2 * HALF_CELL),
        .MID_MIN(MID_EDGE_MIN),
        .TIMEOUT(CARRIER_TIMEOUT)
    ) u_decoder (
        .clk(CLOCK),
        .srst(SRST),
        .line_in(dec_in),
        .rx_data(dec_data),
        .rx_clock(dec_clock),
        .carrier(dec_carrier)
    );

    // Output routing, loopback and monitor flag
    always_comb
    begin
        // RULE_13 inverted then true
        nxt_enc = nxt_active && (nxt_phase ? nxt_bit : !nxt_bit);
        nxt_line_tx = line_on && nxt_enc;
        nxt_line_tx_en = line_on && nxt_active;
        nxt_off_data = 1'b0;
        nxt_off_en = 1'b0;
        nxt_txclk = !nxt_phase;
        nxt_rxdata = dec_data;
        nxt_rxclk = dec_clock;
        nxt_carrier = dec_carrier;
        nxt_col = (mode == LOOP_CODEC) ? 1'b0 : nxt_col_det;
        // RULE_12 bypass to pins
        if (ext_sel)
        begin
            nxt_off_data = MAC_TX_DATA;
            nxt_off_en = MAC_TX_EN;
            nxt_txclk = OFFCHIP_TX_CLOCK;
            nxt_rxdata = OFFCHIP_RX_DATA;
            nxt_rxclk = OFFCHIP_RX_CLOCK;
            nxt_carrier = OFFCHIP_CARRIER;
            nxt_col = OFFCHIP_COLLISION;
        end
        // RULE_09 MAC level loop
        else if (mode == LOOP_MAC)
        begin
            nxt_rxdata = nxt_bit;
            nxt_rxclk = !nxt_phase;
            nxt_carrier = nxt_active;
            nxt_col = 1'b0;
        end
        nxt_tx_en_prev = MAC_TX_EN;
        tx_start = MAC_TX_EN && !tx_en_prev_ff;
        // RULE_10 relies on echo
        mon_fail = MON_CHECK && !(MON_CRC_OK && MON_SRC_OK);
        // RULE_11 set beats clear
        nxt_mon = mon_fail || (MONITOR_BAD_FLAG && !tx_start);
    end

    // RULE_08 mirror onto pins
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            enc_ff <= RESET_LEVEL;
            tx_en_prev_ff <= RESET_LEVEL;
            LINE_TX <= RESET_LEVEL;
            LINE_TX_EN <= RESET_LEVEL;
            OFFCHIP_TX_DATA <= RESET_LEVEL;
            OFFCHIP_TX_EN <= RESET_LEVEL;
            MAC_TRANSMIT_BIT_CLOCK <= RESET_LEVEL;
            MAC_RX_DATA <= RESET_LEVEL;
            MAC_RX_CLOCK <= RESET_LEVEL;
            MAC_CARRIER_PRESENT <= RESET_LEVEL;
            MAC_COLLISION <= RESET_LEVEL;
            PIN_TRANSMIT_BIT_CLOCK <= RESET_LEVEL;
            PIN_RX_CLOCK <= RESET_LEVEL;
            PIN_RX_DATA <= RESET_LEVEL;
            PIN_CARRIER_PRESENT <= RESET_LEVEL;
            PIN_COLLISION <= RESET_LEVEL;
            MONITOR_BAD_FLAG <= RESET_LEVEL;
        end
        else
        begin
            enc_ff <= nxt_enc;
            tx_en_prev_ff <= nxt_tx_en_prev;
            LINE_TX <= nxt_line_tx;
            LINE_TX_EN <= nxt_line_tx_en;
            OFFCHIP_TX_DATA <= nxt_off_data;
            OFFCHIP_TX_EN <= nxt_off_en;
            MAC_TRANSMIT_BIT_CLOCK <= nxt_txclk;
            MAC_RX_DATA <= nxt_rxdata;
            MAC_RX_CLOCK <= nxt_rxclk;
            MAC_CARRIER_PRESENT <= nxt_carrier;
            MAC_COLLISION <= nxt_col;
            PIN_TRANSMIT_BIT_CLOCK <= nxt_txclk;
            PIN_RX_CLOCK <= nxt_rxclk;
            PIN_RX_DATA <= nxt_rxdata;
            PIN_CARRIER_PRESENT <= nxt_carrier;
            PIN_COLLISION <= nxt_col;
            MONITOR_BAD_FLAG <= nxt_mon;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    // Transmit bit clock half periods
    sequence s_clk_high;
        !phase_ff [*5];
    endsequence
    sequence s_clk_low;
        phase_ff [*5];
    endsequence

    // Transmit timing, collision, routing and monitor checks
    AST_TXCLK_DIV: assert property ( // RULE_04
        $fell(phase_ff) |-> s_clk_high ##1 s_clk_low)
        else $error("transmit bit clock not a divide by two");
    AST_MID_EDGE: assert property ( // RULE_13
        LINE_TX_EN && $past(LINE_TX_EN) && $rose(phase_ff) |->
            LINE_TX != $past(LINE_TX) && LINE_TX == bit_ff)
        else $error("missing or wrong mid-cell transition");
    AST_COL_SET: assert property ( // RULE_07
        col_edge && col_tmr_ff != '0 && line_on |=>
            MAC_COLLISION)
        else $error("collision tone not flagged");
    AST_PIN_MIRROR: assert property ( // RULE_08
        PIN_CARRIER_PRESENT == MAC_CARRIER_PRESENT &&
        PIN_COLLISION == MAC_COLLISION && PIN_RX_DATA == MAC_RX_DATA &&
        PIN_RX_CLOCK == MAC_RX_CLOCK &&
        PIN_TRANSMIT_BIT_CLOCK == MAC_TRANSMIT_BIT_CLOCK)
        else $error("user pin differs from MAC signal");
    AST_MON_SET: assert property ( // RULE_11
        mon_fail |=> MONITOR_BAD_FLAG [*1] ##1 (MONITOR_BAD_FLAG || tx_start
            || $past(tx_start)))
        else $error("monitor bad flag not set on mismatch");
    AST_MON_HOLD: assert property ( // RULE_11
        MONITOR_BAD_FLAG && !tx_start |=> MONITOR_BAD_FLAG)
        else $error("monitor bad flag lost");
    AST_EXT_ROUTE: assert property ( // RULE_12
        ext_sel |=> !LINE_TX_EN && OFFCHIP_TX_DATA == $past(MAC_TX_DATA) &&
            MAC_CARRIER_PRESENT == $past(OFFCHIP_CARRIER))
        else $error("external codec routing wrong");
    AST_MAC_LOOP: assert property ( // RULE_09
        !ext_sel && mode == LOOP_MAC |=> !LINE_TX_EN &&
            MAC_RX_DATA == bit_ff && MAC_CARRIER_PRESENT == active_ff)
        else $error("MAC loopback path wrong");
    AST_RX_CARRIER: assert property ( // RULE_06
        line_on |=> MAC_CARRIER_PRESENT == $past(dec_carrier) &&
            MAC_RX_DATA == $past(dec_data))
        else $error("receive path not passed to MAC");
endmodule : manchester_line_codec
`default_nettype wire

// ==== tb/coax_xcvr_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module coax_xcvr_model
(
    input wire logic clk,
    input wire logic line_tx,
    input wire logic line_tx_en,
    input wire logic slow,
    input wire logic col_on,
    output logic line_rx,
    output logic line_col
);
    logic [7:0] pipe_ff = 8'h00;
    logic [2:0] col_cnt_ff = 3'h0;
    logic col_lvl_ff = 1'b0;
    logic [1:0] tap;

    // Echo path, short or long delay
    always_ff @(posedge clk)
    begin
        pipe_ff <= {pipe_ff[5:0], line_tx_en, line_tx};
    end

    assign tap = slow ? pipe_ff[7:6] : pipe_ff[1:0];
    // Released pair rests at its bias level of 0
    assign line_rx = tap[1] & tap[0];

    // 10 MHz collision tone while commanded
    always_ff @(posedge clk)
    begin
        if (col_cnt_ff == 3'h4 || !col_on)
            col_cnt_ff <= 3'h0;
        else
            col_cnt_ff <= col_cnt_ff + 3'h1;
        if (!col_on)
            col_lvl_ff <= 1'b0;
        else if (col_cnt_ff == 3'h4)
            col_lvl_ff <= ~col_lvl_ff;
    end
    assign line_col = col_lvl_ff;
endmodule : coax_xcvr_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb
    import line_codec_pkg::*;
;
    logic CLOCK, SRST, MAC_TX_DATA, MAC_TX_EN, EXTERNAL_CODEC_SELECT;
    logic [1:0] LOOP_MODE;
    logic LINE_RX, LINE_COL, OFFCHIP_TX_CLOCK, OFFCHIP_RX_DATA;
    logic OFFCHIP_RX_CLOCK, OFFCHIP_CARRIER, OFFCHIP_COLLISION;
    logic MON_CHECK, MON_CRC_OK, MON_SRC_OK, slow, col_on;
    logic LINE_TX, LINE_TX_EN, OFFCHIP_TX_DATA, OFFCHIP_TX_EN;
    logic MAC_TRANSMIT_BIT_CLOCK, MAC_RX_DATA, MAC_RX_CLOCK;
    logic MAC_CARRIER_PRESENT, MAC_COLLISION, PIN_TRANSMIT_BIT_CLOCK;
    logic PIN_RX_CLOCK, PIN_RX_DATA, PIN_CARRIER_PRESENT, PIN_COLLISION;
    logic MONITOR_BAD_FLAG;
    logic prev_rxc = 1'b0;
    logic rx_q[$];
    int error_cnt = 0;
    int check_count = 0;

    manchester_line_codec DUT (
        .CLOCK, .SRST, .MAC_TX_DATA, .MAC_TX_EN, .LOOP_MODE,
        .EXTERNAL_CODEC_SELECT, .LINE_RX, .LINE_COL, .OFFCHIP_TX_CLOCK,
        .OFFCHIP_RX_DATA, .OFFCHIP_RX_CLOCK, .OFFCHIP_CARRIER,
        .OFFCHIP_COLLISION, .MON_CHECK, .MON_CRC_OK, .MON_SRC_OK, .LINE_TX,
        .LINE_TX_EN, .OFFCHIP_TX_DATA, .OFFCHIP_TX_EN,
        .MAC_TRANSMIT_BIT_CLOCK, .MAC_RX_DATA, .MAC_RX_CLOCK,
        .MAC_CARRIER_PRESENT, .MAC_COLLISION, .PIN_TRANSMIT_BIT_CLOCK,
        .PIN_RX_CLOCK, .PIN_RX_DATA, .PIN_CARRIER_PRESENT, .PIN_COLLISION,
        .MONITOR_BAD_FLAG
    );

    coax_xcvr_model xcvr (
        .clk(CLOCK), .line_tx(LINE_TX), .line_tx_en(LINE_TX_EN),
        .slow(slow), .col_on(col_on), .line_rx(LINE_RX), .line_col(LINE_COL)
    );

    // Free running clock
    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    task automatic finish_test();
        $display("Errors %0d, checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask : cyc

    task automatic wait_txc(input logic lvl);
        for (int i = 0; i < 40; i++)
        begin
            if (MAC_TRANSMIT_BIT_CLOCK === lvl)
                return;
            cyc(1);
        end
        chk(1'b0, "tx clock stuck");
        finish_test();
    endtask : wait_txc

    // Capture rx bits at rx clock rise; watch user pin copies
    always @(posedge CLOCK)
    begin
        #1;
        if (MAC_RX_CLOCK === 1'b1 && prev_rxc === 1'b0 &&
            MAC_CARRIER_PRESENT === 1'b1)
            rx_q.push_back(MAC_RX_DATA);
        prev_rxc = MAC_RX_CLOCK;
        chk({PIN_TRANSMIT_BIT_CLOCK, PIN_RX_CLOCK, PIN_RX_DATA,
             PIN_CARRIER_PRESENT, PIN_COLLISION} === {MAC_TRANSMIT_BIT_CLOCK,
             MAC_RX_CLOCK, MAC_RX_DATA, MAC_CARRIER_PRESENT, MAC_COLLISION},
            "pin copy");
    end

    task automatic reset_check();
        chk({LINE_TX, LINE_TX_EN, MAC_TRANSMIT_BIT_CLOCK, MAC_CARRIER_PRESENT,
             MONITOR_BAD_FLAG} === 5'h00, "reset levels");
    endtask : reset_check

    task automatic txclk_check();
        int hi = 0;
        int lo = 0;
        // Skip the short first high phase after reset
        wait_txc(1'b1);
        wait_txc(1'b0);
        wait_txc(1'b1);
        while (MAC_TRANSMIT_BIT_CLOCK === 1'b1 && hi < 20)
        begin
            hi++;
            cyc(1);
        end
        while (MAC_TRANSMIT_BIT_CLOCK === 1'b0 && lo < 20)
        begin
            lo++;
            cyc(1);
        end
        chk(hi == HALF_CELL_CYCLES && lo == HALF_CELL_CYCLES,
            "tx clock");
    endtask : txclk_check

    task automatic send_frame(input logic [1:0] mode, input logic slw);
        logic [7:0] pat = 8'hB2;
        logic drive;
        int n;
        drive = (mode == 2'h0 || mode == 2'h3);
        LOOP_MODE = mode;
        slow = slw;
        rx_q.delete();
        wait_txc(1'b1);
        wait_txc(1'b0);
        MAC_TX_EN = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            MAC_TX_DATA = pat[i];
            wait_txc(1'b1);
            cyc(2);
            chk(LINE_TX_EN === drive && LINE_TX === (drive & ~pat[i]),
                "tx first half");
            wait_txc(1'b0);
            chk(LINE_TX === (drive & pat[i]), "tx second half");
        end
        MAC_TX_EN = 1'b0;
        chk(MAC_CARRIER_PRESENT === 1'b1, "carrier lost");
        cyc(14);
        n = rx_q.size();
        chk(n >= 6, "rx bit count");
        for (int i = 0; i < 6 && n >= 6; i++)
            chk(rx_q[n - 6 + i] === pat[5 - i], "rx data");
        cyc(20);
        chk(MAC_CARRIER_PRESENT === 1'b0, "carrier stuck");
    endtask : send_frame

    task automatic col_check(input logic [1:0] mode, input logic exp);
        LOOP_MODE = mode;
        col_on = 1'b1;
        cyc(20);
        chk(MAC_COLLISION === exp, "collision level");
        col_on = 1'b0;
        cyc(25);
        chk(MAC_COLLISION === 1'b0, "collision stuck");
    endtask : col_check

    task automatic mon_check();
        for (int i = 1; i < 4; i++)
        begin
            {MON_CRC_OK, MON_SRC_OK} = i[1:0];
            MON_CHECK = 1'b1;
            cyc(1);
            MON_CHECK = 1'b0;
            chk(MONITOR_BAD_FLAG === (i != 3), "monitor set");
            cyc(4);
            chk(MONITOR_BAD_FLAG === (i != 3), "monitor sticky");
            MAC_TX_EN = 1'b1;
            cyc(12);
            chk(MONITOR_BAD_FLAG === 1'b0, "monitor clear");
            MAC_TX_EN = 1'b0;
            cyc(40);
        end
        // Mismatch and transmit start in one cycle: set wins
        {MON_CRC_OK, MON_SRC_OK} = 2'h0;
        MON_CHECK = 1'b1;
        MAC_TX_EN = 1'b1;
        cyc(1);
        MON_CHECK = 1'b0;
        chk(MONITOR_BAD_FLAG === 1'b1, "monitor set wins");
        MAC_TX_EN = 1'b0;
        cyc(2);
        MAC_TX_EN = 1'b1;
        cyc(2);
        chk(MONITOR_BAD_FLAG === 1'b0, "monitor clear again");
        MAC_TX_EN = 1'b0;
        cyc(40);
    endtask : mon_check

    task automatic ext_check();
        EXTERNAL_CODEC_SELECT = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            {OFFCHIP_RX_DATA, OFFCHIP_RX_CLOCK, OFFCHIP_CARRIER,
             OFFCHIP_COLLISION} = i[0] ? 4'h5 : 4'hA;
            {OFFCHIP_TX_CLOCK, MAC_TX_DATA, MAC_TX_EN} = i[0] ? 3'h0 : 3'h7;
            cyc(3);
            chk({MAC_RX_DATA, MAC_RX_CLOCK, MAC_CARRIER_PRESENT, MAC_COLLISION}
                === (i[0] ? 4'h5 : 4'hA), "bypass rx");
            chk({MAC_TRANSMIT_BIT_CLOCK, OFFCHIP_TX_DATA, OFFCHIP_TX_EN,
                 LINE_TX_EN} === (i[0] ? 4'h0 : 4'hE), "bypass tx");
        end
        EXTERNAL_CODEC_SELECT = 1'b0;
        cyc(30);
    endtask : ext_check

    // Main sequence
    initial
    begin
        {SRST, MAC_TX_DATA, MAC_TX_EN, EXTERNAL_CODEC_SELECT} = 4'h8;
        {OFFCHIP_TX_CLOCK, OFFCHIP_RX_DATA, OFFCHIP_RX_CLOCK} = 3'h0;
        {OFFCHIP_CARRIER, OFFCHIP_COLLISION, MON_CHECK} = 3'h0;
        {MON_CRC_OK, MON_SRC_OK, slow, col_on} = 4'hC;
        LOOP_MODE = 2'h0;
        prev_rxc = 1'b0;
        cyc(3);
        reset_check();
        SRST = 1'b0;
        txclk_check();
        send_frame(2'h0, 1'b0);
        send_frame(2'h0, 1'b1);
        send_frame(2'h1, 1'b0);
        send_frame(2'h2, 1'b0);
        send_frame(2'h3, 1'b1);
        col_check(2'h0, 1'b1);
        col_check(2'h2, 1'b0);
        LOOP_MODE = 2'h0;
        mon_check();
        ext_check();
        finish_test();
    end
endmodule : tb
`default_nettype wire
